// ### geib_edge_sync.sv
/*
 * Two-flop synchroniser with edge detection, one lane per input bit.
 * Assumes inputs are asynchronous to clk_sys; rise/fall are one-cycle
 * pulses derived only from the second and third flops.
 */
`timescale 1ns/1ps
`default_nettype none

module geib_edge_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} geib_sync_t;

	geib_sync_t s;
	geib_sync_t next_s;

	always_comb begin
		next_s = s;
		next_s.meta = async_in;
		next_s.sync = s.meta;
		next_s.prev = s.sync;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s <= '0;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	assign level = s.sync;
	assign rise = s.sync & ~s.prev;
	assign fall = ~s.sync & s.prev;

endmodule

`default_nettype wire

// ### geib_host_model.sv
/* system controller model: sends 128-bit frames on the serial pins.
   assumes clk_sys at 40 MHz; sibclk is eight clk_sys cycles a bit. */
`timescale 1ns/1ps
`default_nettype none
module geib_host_model (
	input wire logic clk_sys,
	input wire logic sibdout,
	input wire logic sibdout_oe,
	output logic sibclk,
	output logic sibsync,
	output logic sibdin
);
	// ------------------------------------------------------------
	// one frame; sibclk stands low between frames
	// ------------------------------------------------------------
	logic [15:0] rdata;
	logic oe2;
	initial begin
		sibclk = 1'b0;
		sibsync = 1'b0;
		sibdin = 1'b0;
	end
	task automatic frame(input logic w, input logic [3:0] a,
		input logic [15:0] d);
		logic b;
		b = 1'b0;
		for (int n = 0; n < 128; n++) begin
			// unused bits toggle so a stale level cannot pass
			b = n[0];
			if (n >= 17 && n <= 20)
				b = a[20-n];
			if (n == 21)
				b = w;
			if (n >= 48 && n <= 63)
				b = d[63-n];
			@(posedge clk_sys);
			// sampled at the next rise, where the last bit still stands
			// a floating pad reads as the inverse, so a lost enable shows
			if (n >= 49 && n <= 64)
				rdata[64-n] = sibdout_oe ? sibdout : ~sibdout;
			if (n == 100)
				oe2 = sibdout_oe;
			sibclk <= 1'b1;
			sibsync <= (n == 0);
			sibdin <= b;
			repeat (4) @(posedge clk_sys);
			sibclk <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		sibdin <= ~b;
	endtask
endmodule
`default_nettype wire

// ### geib_pkg.sv
/*
 * Constants and state types shared by the pin/interrupt block.
 * Assumes a single clk_sys domain; serial link pins are sampled in it.
 */
`default_nettype none

package geib_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int PIN_W = 10;
	localparam int SRC_W = 16;
	localparam int ADDR_W = 4;
	localparam int LINK_W = 3;

	// ----------------------------------------------------------------
	// register addresses (serial frame address field)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_PIN_VALUE = 4'h0;
	localparam logic [3:0] ADDR_PIN_DIRECTION = 4'h1;
	localparam logic [3:0] ADDR_RISE_ENABLE = 4'h2;
	localparam logic [3:0] ADDR_FALL_ENABLE = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SIB_ZERO_BIT = 15;
	localparam int SRC_ADC_READY = 11;
	localparam int SRC_TSPX_LOW = 12;
	localparam int SRC_TSMX_LOW = 13;
	localparam int SRC_TEL_CLIP = 14;
	localparam int SRC_AUD_CLIP = 15;
	// bit 10 is reserved in all source registers
	localparam logic [15:0] SRC_MASK = 16'hfbff;

	// link sampler lanes
	localparam int LINK_CLK = 0;
	localparam int LINK_SYNC = 1;
	localparam int LINK_DIN = 2;

	// ----------------------------------------------------------------
	// serial frame bit positions
	// ----------------------------------------------------------------
	localparam logic [6:0] BIT_ADDR_FIRST = 7'h11;
	localparam logic [6:0] BIT_ADDR_LAST = 7'h14;
	localparam logic [6:0] BIT_WRITE = 7'h15;
	localparam logic [6:0] BIT_RDATA_FIRST = 7'h30;
	localparam logic [6:0] BIT_RDATA_LAST = 7'h3f;
	localparam logic [6:0] BIT_SECOND_WORD = 7'h40;
	localparam logic [6:0] BIT_FRAME_LAST = 7'h7f;
	localparam logic [6:0] BIT_AFTER_FIRST = 7'h01;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [9:0] RST_PIN_VALUE = 10'h000;
	localparam logic [9:0] RST_PIN_DIR = 10'h000;
	localparam logic [15:0] RST_ENABLE = 16'h0000;
	localparam logic [15:0] RST_STATUS = 16'h0000;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [9:0] pin_value;
		logic [9:0] pin_dir;
		logic sib_zero;
		logic [15:0] rise_en;
		logic [15:0] fall_en;
		logic [15:0] status;
		logic [15:0] clr_last;
		logic in_frame;
		logic [6:0] bit_cnt;
		logic [3:0] addr;
		logic wr_req;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [4:0][15:0] snap;
		logic sdo;
		logic sdo_oe;
		logic irq;
	} geib_state_t;

	localparam geib_state_t GEIB_RST_STATE = '0;

endpackage

`default_nettype wire

// ### geib_top.sv
/*
 * General-purpose pins, edge interrupt unit and serial register access.
 * Assumes sibclk, sibsync, sibdin and all event sources are asynchronous
 * and are oversampled by clk_sys (40 MHz); the pad wire for sibdout and
 * the gpio pins is resolved outside from the enables.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: each of the ten pins is an output when its direction bit is 1, else an input.
// RULE2: an output pin drives the last value written to its pin data bit.
// RULE3: reading the pin data register returns the live pin levels.
// RULE4: edges on the pins, both clips, converter-ready and both touch lows can be flagged.
// RULE5: rising enables sit at 9:0 pins, 11 ready, 12 and 13 touch, 14 telecom, 15 audio.
// RULE6: falling enables use the same positions in their own register, both may be on.
// RULE7: reading the status register returns the latched status of every source.
// RULE8: writing a 0-to-1 transition on a status bit clears that source's status.
// RULE9: the interrupt output is the OR of all latched status bits.
// RULE10: edge detection and latching run without the serial clock.
// RULE11: sib_zero high drives sibdout low in the second word, else it floats there.
// RULE12: a status bit sets only on an enabled edge and stays set until cleared.
// RULE13: a register write with the write bit set lands during frame bit 64.
// RULE14: read data are taken from a snapshot made as the frame starts.

module geib_top
	import geib_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic sibclk,
	input wire logic sibsync,
	input wire logic sibdin,
	output logic sibdout,
	output logic sibdout_oe,
	input wire logic [9:0] gpio_in,
	output logic [9:0] gpio_out,
	output logic [9:0] gpio_oe,
	input wire logic adc_ready,
	input wire logic tspx_low,
	input wire logic tsmx_low,
	input wire logic tel_clip,
	input wire logic aud_clip,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// input sampling
	// ----------------------------------------------------------------
	logic [15:0] src_raw;
	logic [15:0] src_level;
	logic [15:0] src_rise;
	logic [15:0] src_fall;
	logic [2:0] link_raw;
	logic [2:0] link_level;
	logic [2:0] link_rise;
	logic [2:0] link_fall;

	// bit 10 has no source; tied low so it can never flag
	assign src_raw = {aud_clip, tel_clip, tsmx_low, tspx_low, adc_ready,
		1'b0, gpio_in};
	assign link_raw = {sibdin, sibsync, sibclk};

	// clk_sys keeps running in power-down, so events latch with sibclk off
	geib_edge_sync #(
		.W(SRC_W)
	) u_src_sync ( // see RULE10
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(src_raw),
		.level(src_level),
		.rise(src_rise),
		.fall(src_fall)
	);

	geib_edge_sync #(
		.W(LINK_W)
	) u_link_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(link_raw),
		.level(link_level),
		.rise(link_rise),
		.fall(link_fall)
	);

	logic sclk_rise;
	logic sclk_fall;
	logic sync_lvl;
	logic din_lvl;

	assign sclk_rise = link_rise[LINK_CLK];
	assign sclk_fall = link_fall[LINK_CLK];
	assign sync_lvl = link_level[LINK_SYNC];
	assign din_lvl = link_level[LINK_DIN];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	geib_state_t s;
	geib_state_t next_s;

	// ----------------------------------------------------------------
	// edge qualification and frame field decode
	// ----------------------------------------------------------------
	logic [15:0] src_hit;
	logic in_addr;
	logic in_rdata;
	logic in_second;
	logic at_write_bit;
	logic at_last_bit;

	// reserved bit 10 is masked per lane, so a stray enable cannot flag
	for (genvar gi = 0; gi < SRC_W; gi++) begin : g_src
		assign src_hit[gi] = SRC_MASK[gi]
			& ((src_rise[gi] & s.rise_en[gi])
			| (src_fall[gi] & s.fall_en[gi])); // see RULE12
	end

	assign in_addr = s.bit_cnt >= BIT_ADDR_FIRST
		&& s.bit_cnt <= BIT_ADDR_LAST;
	assign in_rdata = s.bit_cnt >= BIT_RDATA_FIRST
		&& s.bit_cnt <= BIT_RDATA_LAST;
	assign in_second = s.bit_cnt >= BIT_SECOND_WORD;
	assign at_write_bit = s.bit_cnt == BIT_RDATA_LAST;
	assign at_last_bit = s.bit_cnt == BIT_FRAME_LAST;

	// ----------------------------------------------------------------
	// read view of the registers
	// ----------------------------------------------------------------
	logic [4:0][15:0] reg_view;

	always_comb begin
		reg_view[ADDR_PIN_VALUE] = {6'h00, src_level[9:0]}; // see RULE3
		reg_view[ADDR_PIN_DIRECTION] = {s.sib_zero, 5'h00, s.pin_dir};
		reg_view[ADDR_RISE_ENABLE] = s.rise_en;
		reg_view[ADDR_FALL_ENABLE] = s.fall_en;
		reg_view[ADDR_IRQ_STATUS] = s.status; // see RULE7
	end

	function automatic logic [15:0] read_mux(
		input logic [3:0] a,
		input logic [4:0][15:0] v
	);
		logic [15:0] r;
		r = 16'h0000;
		case (a)
			ADDR_PIN_VALUE: r = v[ADDR_PIN_VALUE];
			ADDR_PIN_DIRECTION: r = v[ADDR_PIN_DIRECTION];
			ADDR_RISE_ENABLE: r = v[ADDR_RISE_ENABLE];
			ADDR_FALL_ENABLE: r = v[ADDR_FALL_ENABLE];
			ADDR_IRQ_STATUS: r = v[ADDR_IRQ_STATUS];
			// registers held elsewhere in the device read as zero here
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	logic [15:0] set_bits;
	logic [15:0] clear_bits;
	logic [15:0] wword;
	logic do_write;
	logic [3:0] rd_idx;

	always_comb begin
		next_s = s;
		set_bits = src_hit; // see RULE4 see RULE5 see RULE6 see RULE12
		clear_bits = 16'h0000;
		wword = {s.wdata[14:0], din_lvl};
		do_write = 1'b0;
		rd_idx = 4'(BIT_RDATA_LAST - s.bit_cnt);

		// frame capture on falling sibclk
		if (sclk_fall) begin
			if (sync_lvl) begin
				next_s.in_frame = 1'b1;
				next_s.bit_cnt = BIT_AFTER_FIRST;
				next_s.snap = reg_view; // see RULE14
				next_s.addr = 4'h0;
				next_s.wr_req = 1'b0;
				next_s.wdata = 16'h0000;
			end else if (s.in_frame) begin
				if (in_addr) begin
					// first address bit is the MSB
					next_s.addr = {s.addr[2:0], din_lvl};
				end
				if (s.bit_cnt == BIT_WRITE) begin
					next_s.wr_req = din_lvl;
					next_s.rdata = read_mux(s.addr, s.snap); // see RULE14
				end
				if (in_rdata) begin
					next_s.wdata = wword;
				end
				if (at_write_bit && s.wr_req) begin
					do_write = 1'b1; // see RULE13
				end
				if (at_last_bit) begin
					next_s.in_frame = 1'b0;
				end else begin
					next_s.bit_cnt = 7'(s.bit_cnt + BIT_AFTER_FIRST);
				end
			end
		end

		// register write, applied as bit 64 begins
		if (do_write) begin
			case (s.addr)
				ADDR_PIN_VALUE: begin
					next_s.pin_value = wword[9:0]; // see RULE2
				end
				ADDR_PIN_DIRECTION: begin
					next_s.pin_dir = wword[9:0]; // see RULE1
					next_s.sib_zero = wword[SIB_ZERO_BIT];
				end
				ADDR_RISE_ENABLE: begin
					next_s.rise_en = wword & SRC_MASK; // see RULE5
				end
				ADDR_FALL_ENABLE: begin
					next_s.fall_en = wword & SRC_MASK; // see RULE6
				end
				ADDR_IRQ_STATUS: begin
					// only a fresh 0-to-1 against the last written word clears
					clear_bits = wword & ~s.clr_last & SRC_MASK; // see RULE8
					next_s.clr_last = wword & SRC_MASK;
				end
				default: begin
				end
			endcase
		end

		// an edge in the clearing cycle still sets the bit
		next_s.status = (s.status & ~clear_bits) | set_bits; // see RULE12
		next_s.irq = |next_s.status; // see RULE9

		// serial output
		if (!s.in_frame) begin
			next_s.sdo = 1'b0;
			next_s.sdo_oe = 1'b1;
		end else if (in_second) begin
			next_s.sdo = 1'b0;
			next_s.sdo_oe = s.sib_zero; // see RULE11
		end else if (in_addr) begin
			// address echo follows sibdin with the sampler's delay
			next_s.sdo = din_lvl;
			next_s.sdo_oe = 1'b1;
		end else if (sclk_rise) begin
			next_s.sdo_oe = 1'b1;
			if (s.bit_cnt >= BIT_RDATA_FIRST) begin
				next_s.sdo = s.rdata[rd_idx];
			end else begin
				// codec fields and flags are not produced by this block
				next_s.sdo = 1'b0;
			end
		end else begin
			next_s.sdo_oe = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s <= GEIB_RST_STATE;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign gpio_out = s.pin_value; // see RULE2
	assign gpio_oe = s.pin_dir; // see RULE1
	assign sibdout = s.sdo;
	assign sibdout_oe = s.sdo_oe;
	assign irq_out = s.irq;

endmodule

`default_nettype wire

// ### geib_top_assertions.sv
/* port-level checker for geib_top, bound into every instance.
   assumes the host toggles sibclk only inside frames. */
`timescale 1ns/1ps
`default_nettype none
module geib_checker (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sibclk,
	input wire logic sibsync,
	input wire logic sibdout,
	input wire logic sibdout_oe,
	input wire logic [9:0] gpio_in,
	input wire logic [9:0] gpio_out,
	input wire logic [9:0] gpio_oe,
	input wire logic adc_ready,
	input wire logic tspx_low,
	input wire logic tsmx_low,
	input wire logic tel_clip,
	input wire logic aud_clip,
	input wire logic irq_out
);
	// ------------------------------------------------------------
	// raw frame position and time since a source moved
	// ------------------------------------------------------------
	logic clk_q;
	logic [6:0] bitn;
	logic [3:0] since_src;
	logic [15:0] src;
	logic [15:0] src_q;
	assign src = {aud_clip, tel_clip, tsmx_low, tspx_low, adc_ready, 1'b0,
		gpio_in};
	always_ff @(posedge clk_sys) begin
		clk_q <= sibclk;
		src_q <= src;
		if (sys_rst) begin
			bitn <= 7'h00;
			since_src <= 4'hf;
		end else begin
			if (src != src_q)
				since_src <= 4'h0;
			else if (since_src != 4'hf)
				since_src <= since_src + 4'h1;
			// counted on the raw pins, so the design lags a few cycles
			if (clk_q && !sibclk)
				bitn <= sibsync ? 7'h01 : (bitn == 7'h00 ? 7'h00 : bitn + 7'h01);
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_write_slot;
		bitn == 7'h40 || bitn == 7'h41;
	endsequence
	sequence s_idle;
		(bitn == 7'h00) [*8];
	endsequence
	a_oe_write_slot: assert property ($changed(gpio_oe) |-> s_write_slot)
		else $error("gpio_oe moved outside the write slot");
	a_out_write_slot: assert property ($changed(gpio_out) |-> s_write_slot)
		else $error("gpio_out moved outside the write slot");
	a_irq_clear_slot: assert property ($fell(irq_out) |-> s_write_slot)
		else $error("irq_out dropped outside the write slot");
	a_irq_from_edge: assert property ($rose(irq_out) |-> since_src < 4'h7)
		else $error("irq_out rose with no recent source edge");
	a_first_word_oe: assert property (bitn >= 7'h02 && bitn <= 7'h3f |-> sibdout_oe)
		else $error("sibdout not driven in the first word");
	a_second_low: assert property (bitn >= 7'h42 |-> !sibdout)
		else $error("sibdout high in the second word");
	a_second_oe: assert property (bitn >= 7'h42 && bitn < 7'h7f |=> $stable(sibdout_oe))
		else $error("sibdout_oe moved inside the second word");
	a_idle_drive: assert property (s_idle |=> sibdout_oe && !sibdout)
		else $error("sibdout not held low between frames");
endmodule
bind geib_top geib_checker u_chk (.clk_sys, .sys_rst, .sibclk, .sibsync,
	.sibdout, .sibdout_oe, .gpio_in, .gpio_out, .gpio_oe, .adc_ready,
	.tspx_low, .tsmx_low, .tel_clip, .aud_clip, .irq_out);
`default_nettype wire

// ### tb_gpio_edge_interrupt_block.sv
/* self-checking bench for geib_top: registers, pins, edges, clears.
   assumes the host model owns the serial pins; clk_en is held high. */
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_edge_interrupt_block
	import geib_pkg::*;
;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] ev = 16'h0000;
	wire logic sibclk, sibsync, sibdin, sibdout, sibdout_oe, irq_out;
	wire logic [9:0] gpio_out, gpio_oe, gpio_in;
	int err_total = 0;
	int checks_done = 0;
	logic [15:0] r, f, v, q, st;
	// pad level: the pin follows the driver only while enabled
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ev[9:0]);
	geib_top DUT (.clk_sys, .sys_rst, .clk_en(1'b1), .sibclk, .sibsync,
		.sibdin, .sibdout, .sibdout_oe, .gpio_in, .gpio_out, .gpio_oe,
		.adc_ready(ev[11]), .tspx_low(ev[12]), .tsmx_low(ev[13]),
		.tel_clip(ev[14]), .aud_clip(ev[15]), .irq_out);
	geib_host_model host (.clk_sys, .sibdout, .sibdout_oe, .sibclk,
		.sibsync, .sibdin);
	initial forever #12.5 clk_sys = ~clk_sys;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// random data field on reads must never be written
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		host.frame(1'b0, a, 16'($urandom));
		d = host.rdata;
	endtask
	function automatic logic [15:0] edges(input logic [15:0] o, n, re, fe);
		return ((re & n & ~o) | (fe & o & ~n)) & SRC_MASK;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#1100us;
		err_total++;
		conclude();
	end
	initial begin
		void'($urandom(91299));
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		for (int a = 0; a < 6; a++) begin
			rd(4'(a), q);
			chk("reset read", 16'h0000, q);
		end
		$display("test reset done");
		v = 16'($urandom);
		r = {6'h00, 10'($urandom)};
		host.frame(1'b1, ADDR_PIN_VALUE, v);
		host.frame(1'b1, ADDR_PIN_DIRECTION, r);
		chk("gpio_out", {6'h00, v[9:0]}, {6'h00, gpio_out});
		chk("gpio_oe", r, {6'h00, gpio_oe});
		ev[9:0] <= 10'($urandom);
		repeat (4) @(posedge clk_sys);
		rd(ADDR_PIN_VALUE, q);
		chk("pins", {6'h00, (r[9:0] & v[9:0]) | (~r[9:0] & ev[9:0])}, q);
		$display("test pins done");
		for (int z = 1; z >= 0; z--) begin
			host.frame(1'b1, ADDR_PIN_DIRECTION, {z[0], 15'h0000});
			rd(ADDR_PIN_DIRECTION, q);
			chk("dir", {z[0], 15'h0000}, q);
			chk("second oe", {15'h0000, z[0]}, {15'h0000, host.oe2});
		end
		$display("test second word done");
		r = 16'($urandom);
		f = 16'($urandom);
		host.frame(1'b1, ADDR_RISE_ENABLE, r);
		chk("old data", 16'h0000, host.rdata);
		host.frame(1'b1, ADDR_FALL_ENABLE, f);
		rd(ADDR_RISE_ENABLE, q);
		chk("rise_en", r & SRC_MASK, q);
		rd(ADDR_FALL_ENABLE, q);
		chk("fall_en", f & SRC_MASK, q);
		st = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? ~ev : 16'($urandom);
			st |= edges(ev, v, r, f);
			ev <= v;
			repeat (8) @(posedge clk_sys);
			chk("irq", {15'h0000, |st}, {15'h0000, irq_out});
			rd(ADDR_IRQ_STATUS, q);
			chk("status", st, q);
		end
		$display("test edges done");
		for (int p = 0; p < 2; p++) begin
			host.frame(1'b1, ADDR_IRQ_STATUS, 16'h0000);
			v = (p == 1) ? 16'hffff : st & 16'($urandom);
			host.frame(1'b1, ADDR_IRQ_STATUS, v);
			st &= ~v;
			rd(ADDR_IRQ_STATUS, q);
			chk("cleared", st, q);
			chk("irq clr", {15'h0000, |st}, {15'h0000, irq_out});
		end
		$display("test clear done");
		conclude();
	end
endmodule
`default_nettype wire
